// file: scsd_clock_sync.sv
// Behaviour
// (RULE_01) DI rising edge rounds clock to minute
// (RULE_02) Source holds pulse high 50 ms
// (RULE_03) Input select: none or six inputs
// (RULE_04) Under four seconds never step backwards
// (RULE_05) Internal source after 1.5 minutes silence
// (RULE_06) Each sync updates reported source
// (RULE_07) Source: internal, input, protocol, timecode
// (RULE_08) Sixteen-bit count of accepted syncs
// (RULE_09) Latest deviation in ms, saturated
// (RULE_10) Filtered deviation within 125 ms, applied
// (RULE_11) Filter smooths jitter between syncs
// (RULE_12) Signed offset added to sync time
// (RULE_13) Periodic 1 ms auto-adjust with sign
// (RULE_14) Learn interval and sign from deviations
// (RULE_15) Zone offset for network time
// (RULE_16) Summer time enable for network time
// (RULE_17) Accept both timecode formats
// (RULE_18) Pulse input delay configured zero
// (RULE_19) Correct softly toward zero deviation
// (RULE_20) Time write loads clock, restarts measurement
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module scsd_clock_sync
    import scsd_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEF,
    parameter bit IRIG_FITTED = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] physical_inputs,
    input wire logic proto_valid,
    input wire logic proto_is_sntp,
    input wire logic [26:0] proto_time_ms,
    input wire logic irig_valid,
    input wire logic [26:0] irig_time_ms,
    output logic [26:0] time_of_day_ms,
    output logic [15:0] day_count,
    output logic [1:0] active_sync_source
);
    localparam int CW = $clog2(CYC_PER_MS);

    function automatic logic signed [31:0] sat(input logic signed [31:0] v, input int lim);
        if (v > lim) return lim;
        if (v < -lim) return -lim;
        return v;
    endfunction

    function automatic logic signed [31:0] day_norm(input logic signed [31:0] v);
        if (v >= DAY_MS) return v - DAY_MS;
        if (v < 0) return v + DAY_MS;
        return v;
    endfunction

    function automatic logic [27:0] adv(input logic [26:0] t, input logic [1:0] n);
        logic [27:0] s;
        s = {1'b0, t} + {26'h0, n};
        if (s >= 28'(DAY_MS)) return {1'b1, 27'(s - 28'(DAY_MS))};
        return {1'b0, s[26:0]};
    endfunction

    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] pulse_sync_input_select;
    logic summer_time_enable;
    logic drift_sign;
    logic signed [15:0] zone_offset_hours;
    logic signed [31:0] sync_offset_comp;
    logic [19:0] autoadjust_interval;
    logic [26:0] time_ff;
    logic [15:0] day_ff;
    logic signed [15:0] corr_ff;
    logic [CW-1:0] cyc_ff;
    logic [19:0] aa_cnt_ff;
    logic [16:0] since_ff;
    scsd_src_e src_ff;
    logic [15:0] sync_event_count;
    logic signed [15:0] dev_ff;
    logic signed [15:0] last_dev_ff;
    logic signed [7:0] filtered_deviation_ms;
    logic di_prev_ff;
    logic apb_wr;
    logic time_wr;
    logic addr_hit;
    logic [31:0] rd_data;
    logic ms_tick;
    logic aa_fire;
    logic di_lvl;
    logic di_evt;
    logic irig_evt;
    logic sync_evt;
    scsd_src_e evt_src;
    logic [16:0] rem;
    logic signed [31:0] t_s;
    logic signed [31:0] ref_raw;
    logic signed [31:0] ref_n;
    logic signed [31:0] dev_w;
    logic signed [31:0] dev_sat;
    logic signed [31:0] filt_calc;
    logic big;
    logic learn;
    logic [27:0] stepped;
    logic [26:0] nxt_time;
    logic [15:0] nxt_day;
    logic signed [15:0] nxt_corr;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign time_of_day_ms = time_ff;
    assign day_count = day_ff;
    assign active_sync_source = src_ff;

    // APB slave: one wait-free access phase, error on unmapped address
    assign apb_wr = psel && penable && pwrite && pready_ff;
    assign time_wr = apb_wr && paddr == REG_TIME && pwdata < 32'(DAY_MS);
    assign addr_hit = paddr[1:0] == 2'h0 && paddr <= REG_DEV;

    always_comb begin
        case (paddr)
            REG_CTRL: rd_data = {27'h0, drift_sign, summer_time_enable, pulse_sync_input_select};
            REG_ZONE: rd_data = {{16{zone_offset_hours[15]}}, zone_offset_hours};
            REG_OFFS: rd_data = sync_offset_comp;
            REG_AAIV: rd_data = {12'h0, autoadjust_interval};
            REG_TIME: rd_data = {5'h0, time_ff};
            REG_DAY: rd_data = {16'h0, day_ff};
            REG_STAT: rd_data = {sync_event_count, 14'h0, src_ff};
            REG_DEV: rd_data = {{8{filtered_deviation_ms[7]}}, filtered_deviation_ms, dev_ff};
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= psel && !penable && !pready_ff;
            pslverr_ff <= psel && !penable && !pready_ff && !addr_hit;
            if (psel && !penable) begin
                prdata_ff <= addr_hit ? rd_data : 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_sync_input_select <= SEL_NONE;
            summer_time_enable <= 1'b0;
            zone_offset_hours <= 16'sh0;
            sync_offset_comp <= 32'sh0;
        end else if (apb_wr) begin
            if (paddr == REG_CTRL) begin
                pulse_sync_input_select <= pwdata[2:0] > SEL_LAST ? SEL_NONE : pwdata[CTRL_SEL_MSB:CTRL_SEL_LSB];
                summer_time_enable <= pwdata[CTRL_DST_BIT];
            end
            if (paddr == REG_ZONE) begin
                zone_offset_hours <= 16'(sat(signed'(pwdata), ZONE_LIM));
            end
            if (paddr == REG_OFFS) begin
                sync_offset_comp <= sat(signed'(pwdata), OFFS_LIM);
            end
        end
    end

    // Millisecond base and auto-adjust interval
    assign ms_tick = cyc_ff == CW'(CYC_PER_MS - 1);
    assign aa_fire = ms_tick && autoadjust_interval != 20'h0 && aa_cnt_ff >= autoadjust_interval - 20'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_ff <= '0;
            aa_cnt_ff <= 20'h0;
        end else begin
            cyc_ff <= ms_tick ? '0 : cyc_ff + CW'(1);
            if (autoadjust_interval == 20'h0 || aa_fire) begin
                aa_cnt_ff <= 20'h0;
            end else if (ms_tick) begin
                aa_cnt_ff <= aa_cnt_ff + 20'h1;
            end
        end
    end

    // Sync events; pulse input wins over timecode, timecode over protocol
    always_comb begin
        di_lvl = 1'b0;
        if (pulse_sync_input_select != SEL_NONE) begin // RULE_03
            di_lvl = physical_inputs[pulse_sync_input_select - 3'h1];
        end
    end
    assign di_evt = di_lvl && !di_prev_ff; // RULE_01
    assign irig_evt = IRIG_FITTED && irig_valid; // RULE_17
    assign sync_evt = di_evt || irig_evt || proto_valid;

    always_comb begin
        t_s = signed'({5'h0, time_ff});
        rem = 17'(time_ff % 27'(MIN_MS));
        evt_src = SRC_PROTO;
        if (di_evt) begin
            evt_src = SRC_DI;
            ref_raw = t_s - signed'({15'h0, rem}); // RULE_01
            if (rem >= 17'(HALF_MIN_MS)) begin
                ref_raw = ref_raw + MIN_MS;
            end
        end else if (irig_evt) begin
            evt_src = SRC_IRIG;
            ref_raw = signed'({5'h0, irig_time_ms});
        end else begin
            ref_raw = signed'({5'h0, proto_time_ms});
            if (proto_is_sntp) begin
                ref_raw = ref_raw + zone_offset_hours * ZONE_UNIT_MS; // RULE_15
                if (summer_time_enable) begin
                    ref_raw = ref_raw + HOUR_MS; // RULE_16
                end
            end
        end
        ref_n = day_norm(day_norm(ref_raw + sync_offset_comp)); // RULE_12
        dev_w = t_s - ref_n;
        if (dev_w > HALF_DAY_MS) begin
            dev_w = dev_w - DAY_MS;
        end else if (dev_w < -HALF_DAY_MS) begin
            dev_w = dev_w + DAY_MS;
        end
        dev_sat = sat(dev_w, DEV_SAT); // RULE_09
        filt_calc = sat((dev_sat + last_dev_ff) >>> 1, FILT_LIM); // RULE_11
    end
    assign big = dev_w >= STEP_LIMIT_MS || dev_w <= -STEP_LIMIT_MS; // RULE_04
    assign learn = sync_evt && !big && dev_sat != 32'sh0;

    // Clock update: positive correction holds time, negative advances by two
    always_comb begin
        nxt_corr = corr_ff;
        stepped = adv(time_ff, 2'h0);
        if (ms_tick) begin
            if (corr_ff > 16'sh0) begin
                nxt_corr = corr_ff - 16'sh1; // RULE_04
            end else if (corr_ff < 16'sh0) begin
                nxt_corr = corr_ff + 16'sh1;
                stepped = adv(time_ff, 2'h2);
            end else begin
                stepped = adv(time_ff, 2'h1);
            end
            if (aa_fire) begin
                nxt_corr = drift_sign == DRIFT_LEAD ? nxt_corr + 16'sh1 : nxt_corr - 16'sh1; // RULE_13
            end
        end
        nxt_time = stepped[26:0];
        nxt_day = day_ff + {15'h0, stepped[27]};
        if (sync_evt) begin
            if (big) begin
                nxt_time = ref_n[26:0];
                nxt_corr = 16'sh0;
            end else begin
                nxt_corr = nxt_corr + 16'(filt_calc); // RULE_19
            end
        end
        if (time_wr) begin
            nxt_time = pwdata[26:0]; // RULE_20
            nxt_corr = 16'sh0;
        end
        if (apb_wr && paddr == REG_DAY) begin
            nxt_day = pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_ff <= RST_TIME;
            day_ff <= RST_DAY;
            corr_ff <= 16'sh0;
        end else begin
            time_ff <= nxt_time;
            day_ff <= nxt_day;
            corr_ff <= nxt_corr;
        end
    end

    // Deviation reporting and filter history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_ff <= 16'sh0;
            last_dev_ff <= 16'sh0;
            filtered_deviation_ms <= 8'sh0;
            di_prev_ff <= 1'b0;
        end else begin
            di_prev_ff <= di_lvl;
            if (time_wr) begin
                last_dev_ff <= 16'sh0; // RULE_20
                filtered_deviation_ms <= 8'sh0;
            end else if (sync_evt) begin
                dev_ff <= 16'(dev_sat); // RULE_09
                last_dev_ff <= big ? 16'sh0 : 16'(dev_sat);
                filtered_deviation_ms <= big ? 8'sh0 : 8'(filt_calc); // RULE_10
            end
        end
    end

    // Source indicator, silence timer and event count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ff <= SRC_INTERNAL;
            since_ff <= 17'h0;
            sync_event_count <= 16'h0;
        end else begin
            if (sync_evt) begin
                src_ff <= evt_src; // RULE_06
                since_ff <= 17'h0;
                sync_event_count <= sync_event_count + 16'h1; // RULE_08
            end else begin
                if (ms_tick && since_ff < 17'(SYNC_TIMEOUT_MS)) begin
                    since_ff <= since_ff + 17'h1;
                end
                if (since_ff >= 17'(SYNC_TIMEOUT_MS)) begin
                    src_ff <= SRC_INTERNAL; // RULE_05 RULE_07
                end
            end
        end
    end

    // Auto-adjust setting, written by software and learned from syncs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            autoadjust_interval <= RST_AAIV;
            drift_sign <= 1'b0;
        end else begin
            if (apb_wr && paddr == REG_CTRL) begin
                drift_sign <= pwdata[CTRL_DRIFT_BIT];
            end
            if (apb_wr && paddr == REG_AAIV) begin
                autoadjust_interval <= pwdata > {12'h0, AA_MAX_MS} ? AA_MAX_MS : pwdata[19:0];
            end
            if (learn) begin
                if (autoadjust_interval == 20'h0) begin
                    drift_sign <= dev_sat > 32'sh0; // RULE_14
                    autoadjust_interval <= AA_MAX_MS;
                end else if (drift_sign == (dev_sat > 32'sh0)) begin
                    autoadjust_interval <= autoadjust_interval - (autoadjust_interval >> 2) < AA_MIN_MS ?
                        AA_MIN_MS : autoadjust_interval - (autoadjust_interval >> 2);
                end else if (autoadjust_interval > (AA_MAX_MS >> 1)) begin
                    autoadjust_interval <= 20'h0;
                end else begin
                    autoadjust_interval <= autoadjust_interval << 1;
                end
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_di_round_min: assert property (di_evt && big && !time_wr && sync_offset_comp == 32'sh0 |=> // RULE_01
        (time_ff % 27'(MIN_MS)) == 27'h0)
        else $error("pulse step not on minute");
    a_sel_none_off: assert property (pulse_sync_input_select == SEL_NONE |-> !di_evt) // RULE_03
        else $error("pulse sync while disabled");
    a_small_mono: assert property (sync_evt && !big && !time_wr |=> // RULE_04
        time_ff >= $past(time_ff) || day_ff != $past(day_ff))
        else $error("clock stepped back");
    a_src_timeout: assert property (since_ff >= 17'(SYNC_TIMEOUT_MS) && !sync_evt |=> src_ff == SRC_INTERNAL) // RULE_05
        else $error("no fallback to internal");
    a_src_update: assert property (sync_evt |=> src_ff == $past(evt_src)) // RULE_06
        else $error("source not updated");
    a_count_inc: assert property (sync_evt |=> sync_event_count == $past(sync_event_count) + 16'h1) // RULE_08
        else $error("sync count wrong");
    a_dev_sat: assert property (sync_evt && !time_wr && (dev_w > DEV_SAT || dev_w < -DEV_SAT) |=> // RULE_09
        dev_ff == ($past(dev_w) > 0 ? 16'sh7fff : -16'sh7fff))
        else $error("deviation not saturated");
    a_filt_range: assert property (filtered_deviation_ms <= 8'sh7d && filtered_deviation_ms >= -8'sh7d) // RULE_10
        else $error("filtered deviation out of range");
    a_filt_applied: assert property (sync_evt && !big && !ms_tick && !time_wr |=> // RULE_19
        corr_ff == $past(corr_ff) + filtered_deviation_ms)
        else $error("filtered deviation not applied");
    a_aa_step: assert property (aa_fire && corr_ff == 16'sh0 && !sync_evt && !time_wr |=> // RULE_13
        corr_ff == ($past(drift_sign) ? 16'sh1 : -16'sh1))
        else $error("auto-adjust step missing");
    a_time_load: assert property (time_wr |=> time_ff == $past(pwdata[26:0]) && corr_ff == 16'sh0) // RULE_20
        else $error("time write not loaded");
    a_apb_ready: assert property (psel && !penable && !pready_ff |=> pready_ff ##1 !pready_ff)
        else $error("apb ready timing");

    c_di_sync: cover property (di_evt && !big);
    c_big_step: cover property (sync_evt && big);
    c_timeout: cover property (src_ff != SRC_INTERNAL ##1 src_ff == SRC_INTERNAL);
    c_learn: cover property (learn && autoadjust_interval != 20'h0);
endmodule

// file: scsd_clock_sync_tb_top.sv
`timescale 1ns/1ps
module scsd_clock_sync_tb_top
    import scsd_pkg::*;
;
    localparam int CPM = 10;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] physical_inputs;
    logic proto_valid;
    logic proto_is_sntp;
    logic [26:0] proto_time_ms;
    logic irig_valid;
    logic [26:0] irig_time_ms;
    logic [26:0] time_of_day_ms;
    logic [15:0] day_count;
    logic [1:0] active_sync_source;
    int n_fail;
    int n_compared;
    logic [31:0] d;
    logic e;
    int adv;
    logic mono;
    logic [31:0] expv;

    scsd_clock_sync #(.CYC_PER_MS(CPM), .IRIG_FITTED(1'b1)) scsd_clock_sync_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .physical_inputs(physical_inputs), .proto_valid(proto_valid), .proto_is_sntp(proto_is_sntp),
        .proto_time_ms(proto_time_ms), .irig_valid(irig_valid), .irig_time_ms(irig_time_ms),
        .time_of_day_ms(time_of_day_ms), .day_count(day_count), .active_sync_source(active_sync_source)
    );

    scsd_time_master #(.CYC_PER_MS(CPM)) scsd_time_master_inst (
        .pclk(pclk), .physical_inputs(physical_inputs), .proto_valid(proto_valid),
        .proto_is_sntp(proto_is_sntp), .proto_time_ms(proto_time_ms),
        .irig_valid(irig_valid), .irig_time_ms(irig_time_ms)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        return {31'h0, (v >= lo) && (v <= hi)};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(d, exp);
    endtask

    // Follows the clock for a number of cycles, noting any step back
    task automatic watch(input int cyc);
        logic [26:0] t0;
        logic [26:0] p;
        @(negedge pclk);
        t0 = time_of_day_ms;
        p = t0;
        mono = 1'b1;
        repeat (cyc) begin
            @(negedge pclk);
            if (time_of_day_ms < p)
                mono = 1'b0;
            p = time_of_day_ms;
        end
        adv = int'(p - t0);
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end

    initial begin
        n_fail = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i != 4)
                rdc(8'(i * 4), 32'h0);
        end
        rdc(8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        rdc(8'h02, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, REG_STAT, 32'hffffffff);
        rdc(REG_STAT, 32'h0);
        apb(1'b1, REG_TIME, 32'h05265c00);
        apb(1'b0, REG_TIME, 32'h0);
        chk(rng(d, 32'h0, 32'h14), 32'h1);
        $display("Test registers done");

        apb(1'b1, REG_TIME, 32'h000f4240);
        scsd_time_master_inst.msg(2'h1, 1'b0, 27'h00f41dc);
        apb(1'b0, REG_DEV, 32'h0);
        chk(rng({16'h0, d[15:0]}, 32'h64, 32'h65), 32'h1);
        chk({16'h0, d[31:16]}, 32'h32);
        scsd_time_master_inst.msg(2'h1, 1'b0, 27'h00f4114);
        apb(1'b0, REG_DEV, 32'h0);
        chk(rng({16'h0, d[15:0]}, 32'h12c, 32'h12e), 32'h1);
        chk({16'h0, d[31:16]}, 32'h7d);
        rdc(REG_STAT, 32'h00020002);
        rdc(REG_AAIV, 32'h000b71b0);
        rdc(REG_CTRL, 32'h10);
        watch(3000);
        chk(rng(adv, 32'h7b, 32'h7f), 32'h1);
        chk({31'h0, mono}, 32'h1);
        $display("Test soft correction done");

        apb(1'b1, REG_AAIV, 32'h000f4241);
        rdc(REG_AAIV, 32'h000f4240);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, REG_CTRL, k ? 32'h0 : 32'h10);
            apb(1'b1, REG_AAIV, 32'h3e8);
            apb(1'b1, REG_TIME, 32'h00100000);
            watch(25000);
            chk(rng(adv, k ? 32'h9c5 : 32'h9c0, k ? 32'h9c8 : 32'h9c3), 32'h1);
            chk({31'h0, mono}, 32'h1);
        end
        $display("Test auto adjust done");

        apb(1'b1, REG_TIME, 32'h000f4240);
        scsd_time_master_inst.msg(2'h1, 1'b0, 27'h01e8480);
        rdc(REG_DEV, 32'h00008001);
        apb(1'b0, REG_TIME, 32'h0);
        chk(rng(d, 32'h1e8480, 32'h1e8482), 32'h1);
        rdc(REG_STAT, 32'h00030002);
        $display("Test large step done");

        apb(1'b1, REG_ZONE, 32'h7d0);
        rdc(REG_ZONE, 32'h5dc);
        apb(1'b1, REG_ZONE, 32'h64);
        apb(1'b1, REG_CTRL, 32'h8);
        apb(1'b1, REG_OFFS, 32'h1f4);
        apb(1'b1, REG_TIME, 32'h02625a00);
        scsd_time_master_inst.msg(2'h1, 1'b1, 27'h1f47b0c);
        apb(1'b0, REG_DEV, 32'h0);
        chk(rng({16'h0, d[15:0]}, 32'h0, 32'h3), 32'h1);
        scsd_time_master_inst.msg(2'h1, 1'b0, 27'h262580c);
        apb(1'b0, REG_DEV, 32'h0);
        chk(rng({16'h0, d[15:0]}, 32'h0, 32'h3), 32'h1);
        apb(1'b1, REG_OFFS, 32'h0);
        rdc(REG_STAT, 32'h00050002);
        $display("Test network time done");

        apb(1'b1, REG_TIME, 32'h02faf080);
        scsd_time_master_inst.msg(2'h3, 1'b0, 27'h2faa260);
        rdc(REG_STAT, 32'h00060003);
        apb(1'b0, REG_TIME, 32'h0);
        chk(rng(d, 32'h02faa260, 32'h02faa262), 32'h1);
        chk({30'h0, active_sync_source}, 32'h3);
        $display("Test timecode done");

        apb(1'b1, REG_DAY, 32'h5);
        @(negedge pclk);
        chk({16'h0, day_count}, 32'h5);
        apb(1'b1, REG_TIME, 32'h05265bfb);
        repeat (100) @(negedge pclk);
        chk({16'h0, day_count}, 32'h6);
        chk(rng({5'h0, time_of_day_ms}, 32'h0, 32'h10), 32'h1);
        $display("Test day count done");

        for (int s = 1; s < 7; s++) begin
            apb(1'b1, REG_CTRL, 32'(s));
            scsd_time_master_inst.pulse(s % 6);
            apb(1'b1, REG_TIME, (s % 2) ? 32'h00050910 : 32'h0005090b);
            scsd_time_master_inst.pulse(s - 1);
            expv = (s % 2) ? 32'h00057e40 : 32'h000493e0;
            apb(1'b0, REG_TIME, 32'h0);
            chk(rng(d, expv + 32'h31, expv + 32'h34), 32'h1);
            rdc(REG_STAT, {16'(6 + s), 16'h1});
        end
        apb(1'b1, REG_CTRL, 32'h7);
        rdc(REG_CTRL, 32'h0);
        scsd_time_master_inst.pulse(0);
        rdc(REG_STAT, 32'h000c0001);
        $display("Test minute pulse done");
        end_of_test();
    end
endmodule

// file: scsd_pkg.sv
package scsd_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ZONE = 8'h04;
    localparam logic [7:0] REG_OFFS = 8'h08;
    localparam logic [7:0] REG_AAIV = 8'h0c;
    localparam logic [7:0] REG_TIME = 8'h10;
    localparam logic [7:0] REG_DAY = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam logic [7:0] REG_DEV = 8'h1c;
    // Control fields
    localparam int CTRL_SEL_LSB = 32'h0;
    localparam int CTRL_SEL_MSB = 32'h2;
    localparam int CTRL_DST_BIT = 32'h3;
    localparam int CTRL_DRIFT_BIT = 32'h4;
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_LAST = 3'h6;
    localparam logic DRIFT_LEAD = 1'h1;
    // Timing, in milliseconds unless named otherwise
    localparam int CLK_PERIOD_NS = 32'ha;
    localparam int NS_PER_MS = 32'hf4240;
    localparam int CYC_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;
    localparam int DAY_MS = 32'h05265c00;
    localparam int HALF_DAY_MS = DAY_MS / 2;
    localparam int MIN_MS = 32'hea60;
    localparam int HALF_MIN_MS = 32'h7530;
    localparam int HOUR_MS = 32'h36ee80;
    localparam int ZONE_UNIT_MS = 32'h8ca0;
    localparam int STEP_LIMIT_MS = 32'hfa0;
    localparam int SYNC_TIMEOUT_MS = 32'h15f90;
    localparam int PULSE_MIN_MS = 32'h32;
    // Value ranges
    localparam int DEV_SAT = 32'h7fff;
    localparam int FILT_LIM = 32'h7d;
    localparam int ZONE_LIM = 32'h5dc;
    localparam int OFFS_LIM = 32'h989680;
    localparam logic [19:0] AA_MAX_MS = 20'hf4240;
    localparam logic [19:0] AA_MIN_MS = 20'h003e8;
    // Reset values
    localparam logic [19:0] RST_AAIV = 20'h0;
    localparam logic [26:0] RST_TIME = 27'h0;
    localparam logic [15:0] RST_DAY = 16'h0;
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_DI = 2'b01,
        SRC_PROTO = 2'b10,
        SRC_IRIG = 2'b11
    } scsd_src_e;
endpackage

// file: scsd_time_master.sv
`timescale 1ns/1ps
module scsd_time_master
    import scsd_pkg::*;
#(
    parameter int CYC_PER_MS = 10
) (
    input wire logic pclk,
    output logic [5:0] physical_inputs,
    output logic proto_valid,
    output logic proto_is_sntp,
    output logic [26:0] proto_time_ms,
    output logic irig_valid,
    output logic [26:0] irig_time_ms
);
    initial begin
        physical_inputs = 6'h00;
        proto_valid = 1'b0;
        proto_is_sntp = 1'b0;
        proto_time_ms = 27'h0;
        irig_valid = 1'b0;
        irig_time_ms = 27'h0;
    end

    // Edge marks the minute at once, no input filter delay
    task automatic pulse(input int idx);
        @(posedge pclk);
        physical_inputs[idx] <= 1'b1;
        repeat (PULSE_MIN_MS * CYC_PER_MS) @(posedge pclk);
        physical_inputs[idx] <= 1'b0;
    endtask

    // Bit 0 sends a protocol message, bit 1 a timecode frame
    task automatic msg(input logic [1:0] kind, input logic sntp, input logic [26:0] t);
        @(posedge pclk);
        proto_valid <= kind[0];
        proto_is_sntp <= sntp;
        proto_time_ms <= t;
        irig_valid <= kind[1];
        irig_time_ms <= t;
        @(posedge pclk);
        proto_valid <= 1'b0;
        irig_valid <= 1'b0;
        // Message fields carry inverted values once the valid cycle is over
        proto_is_sntp <= ~sntp;
        proto_time_ms <= ~t;
        irig_time_ms <= ~t;
    endtask
endmodule
